// ---- param_page_map.svh ----
`ifndef PARAM_PAGE_MAP_SVH
`define PARAM_PAGE_MAP_SVH

// ==========================================
// Commands and addresses
`define PP_CMD_READ_PARAM 8'hEC
`define PP_ADDR_PARAM 8'h40

// ==========================================
// Byte offsets inside one copy of the page
`define PP_OFF_SIG_LAST 9'h003
`define PP_OFF_PAGE_BYTES 9'h050
`define PP_OFF_LU_COUNT 9'h064
`define PP_OFF_ADDR_CYC 9'h065
`define PP_OFF_PROGS 9'h067
`define PP_OFF_PLANE_BITS 9'h068
`define PP_OFF_MP_ATTR 9'h069
`define PP_OFF_ASYNC_GRADE 9'h090
`define PP_OFF_STROBE_GRADE 9'h092
`define PP_OFF_COPY_LAST 9'h1FF

// ==========================================
// Field positions, signature and copy counts, reset values
`define PP_ATTR_PROG_CACHE 0
`define PP_ATTR_READ_CACHE 1
`define PP_ATTR_PLANE_FREE 2
`define PP_SIG_MIN_HITS 3'h2
`define PP_COPIES 2'h3
`define PP_FIELD_RESET 8'h00

// ==========================================
// Timing
`define PP_CLK_MHZ 40
`define PP_STROBE_NS 150
`define PP_STROBE_CYC ((`PP_STROBE_NS * `PP_CLK_MHZ + 999) / 1000)
`define PP_WB_NS 100
`define PP_WB_CYC ((`PP_WB_NS * `PP_CLK_MHZ + 999) / 1000)

`endif

// ---- param_page_pkg.sv ----
package param_page_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WR = 3'b001,
    ST_WAIT_WB = 3'b010,
    ST_WAIT_RDY = 3'b011,
    ST_RD = 3'b100,
    ST_FLUSH = 3'b101
  } host_state_t;

  typedef enum logic [1:0] {
    OP_OTHER = 2'b00,
    OP_READ = 2'b01,
    OP_PROGRAM = 2'b10,
    OP_ERASE = 2'b11
  } op_kind_t;

endpackage

// ---- byte_stream_if.sv ----
`timescale 1ns/10ps
`default_nettype none

interface byte_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// ---- stream_fifo.sv ----
`timescale 1ns/10ps
`default_nettype none

module stream_fifo #(
  parameter int W = 8,
  parameter int D = 8,
  parameter int AW = $clog2(D)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Streams
  byte_stream_if.snk in_s,
  byte_stream_if.src out_s
);

  logic [W-1:0] mem_q [D];
  logic [AW:0] wp_q, wp_d, rp_q, rp_d;
  logic full, empty, push, pop;

  // ==========================================
  // Pointers with a wrap bit keep full and empty apart
  assign full = (wp_q[AW-1:0] == rp_q[AW-1:0]) && (wp_q[AW] != rp_q[AW]);
  assign empty = (wp_q == rp_q);
  assign in_s.ready = !full;
  assign out_s.valid = !empty;
  assign out_s.data = mem_q[rp_q[AW-1:0]];
  assign push = in_s.valid && !full;
  assign pop = out_s.ready && !empty;

  always_comb begin
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= in_s.data;
    end
  end

endmodule

`default_nettype wire

// ---- page_mem.sv ----
`timescale 1ns/10ps
`default_nettype none

module page_mem #(
  parameter int AW = 9,
  parameter int W = 8
) (
  // Clock
  input wire logic clk,
  // Single port
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0] rdata
);

  logic [W-1:0] mem_q [2**AW];

  // ==========================================
  // Registered read, one cycle after the address
  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[addr] <= wdata;
    end
    rdata <= mem_q[addr];
  end

endmodule

`default_nettype wire

// ---- param_page_host.sv ----
`include "param_page_map.svh"
`timescale 1ns/10ps
`default_nettype none

module param_page_host
  import param_page_pkg::*;
#(
  parameter int FIFO_DEPTH = 8,
  parameter logic [7:0] SIG0 = 8'h11,  // Arbitrary value
  parameter logic [7:0] SIG1 = 8'h22,  // Arbitrary value
  parameter logic [7:0] SIG2 = 8'h33,  // Arbitrary value
  parameter logic [7:0] SIG3 = 8'h55   // Arbitrary value
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Page read request and result
  input wire logic page_start,
  output logic page_busy,
  output logic page_valid,
  output logic page_fail,
  // Stored page readout
  input wire logic rd_en,
  input wire logic [8:0] rd_addr,
  output logic [7:0] rd_data,
  // Decoded fields
  output logic [3:0] row_cycles,
  output logic [3:0] col_cycles,
  output logic [7:0] logical_unit_count,
  output logic [7:0] programs_per_page,
  output logic [3:0] plane_bits,
  output logic [2:0] mp_attr,
  output logic [31:0] page_bytes,
  output logic [5:0] async_grades,
  output logic [8:0] strobe_grades,
  // Operation request
  input wire logic op_valid,
  input wire op_kind_t op_kind,
  input wire logic [7:0] op_cmd,
  input wire logic [15:0] op_col,
  input wire logic [23:0] op_row,
  input wire logic [7:0] op_logical_unit,
  input wire logic [3:0] op_plane,
  input wire logic op_cache,
  input wire logic op_multi_plane,
  input wire logic op_copyback,
  output logic op_done,
  output logic op_refused,
  // Flash pins
  output logic ce_n,
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic re_n,
  output logic [7:0] dq_out,
  output logic dq_oe,
  input wire logic [7:0] dq_in,
  input wire logic rb_in
);

  localparam logic [7:0] STROBE_LAST = 8'(`PP_STROBE_CYC - 1);
  localparam logic [7:0] WB_CYC = 8'(`PP_WB_CYC);
  localparam logic [10:0] READ_LIMIT = 11'(3 * 512);

  // ==========================================
  // Functions
  function automatic logic [31:0] put_le(input logic [31:0] v, input logic [7:0] b, input logic [1:0] pos);
    logic [31:0] r;
    r = v;
    r[pos*8 +: 8] = b;
    return r;
  endfunction

  function automatic logic [63:0] pack_addr(input logic [15:0] col, input logic [23:0] row, input logic [3:0] cc);
    logic [63:0] colm;
    colm = {48'h0, col} & ~(64'hFFFF_FFFF_FFFF_FFFF << ({2'h0, cc} * 6'h08));
    return colm | ({40'h0, row} << ({2'h0, cc} * 6'h08));
  endfunction

  // ==========================================
  // Pin synchronisers
  logic [7:0] dq_s1, dq_s2, dq_s3, dq_q;
  logic rb_s1, rb_s2, rb_s3, rb_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dq_s1 <= 8'h00;
      dq_s2 <= 8'h00;
      dq_s3 <= 8'h00;
      dq_q <= 8'h00;
      rb_s1 <= 1'b0;
      rb_s2 <= 1'b0;
      rb_s3 <= 1'b0;
      rb_q <= 1'b0;
    end else begin
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
      rb_s1 <= rb_in;
      rb_s2 <= rb_s1;
      rb_s3 <= rb_s2;
      if (dq_s2 == dq_s3) begin
        dq_q <= dq_s3;
      end
      if (rb_s2 == rb_s3) begin
        rb_q <= rb_s3;
      end
    end
  end

  // ==========================================
  // Strobe divider
  logic [7:0] div_q, div_d;
  logic tick;
  assign tick = (div_q == STROBE_LAST);
  always_comb begin
    div_d = tick ? 8'h00 : div_q + 8'h01;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_d;
    end
  end

  // ==========================================
  // Buffer between pins and page store
  byte_stream_if #(.W(8)) fill_s ();
  byte_stream_if #(.W(8)) drain_s ();

  stream_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_s(fill_s),
    .out_s(drain_s)
  );

  // ==========================================
  // Drain and parse
  logic [10:0] didx_q, didx_d;
  logic [2:0] hits_q, hits_d;
  logic stop_q, stop_d, pvalid_q, pvalid_d, pfail_q, pfail_d;
  logic [3:0] rowc_q, rowc_d, colc_q, colc_d, pbits_q, pbits_d;
  logic [7:0] luc_q, luc_d, progs_q, progs_d;
  logic [2:0] attr_q, attr_d;
  logic [31:0] pbytes_q, pbytes_d;
  logic [5:0] async_q, async_d;
  logic [8:0] strobe_q, strobe_d;
  logic drain_take, mem_we, sig_hit, clear_page;
  logic [8:0] off;
  logic [7:0] b;

  // Single port store: user readout wins, drain waits while rd_en is high
  assign drain_s.ready = !rd_en;
  assign drain_take = drain_s.valid && drain_s.ready;
  assign mem_we = drain_take && !stop_q;
  assign off = didx_q[8:0];
  assign b = drain_s.data;
  assign sig_hit = (off == 9'h000 && b == SIG0) || (off == 9'h001 && b == SIG1) ||
                   (off == 9'h002 && b == SIG2) || (off == 9'h003 && b == SIG3);

  page_mem #(.AW(9), .W(8)) u_mem (
    .clk(clk),
    .we(mem_we),
    .addr(rd_en ? rd_addr : off),
    .wdata(b),
    .rdata(rd_data)
  );

  always_comb begin
    didx_d = didx_q;
    hits_d = hits_q;
    stop_d = stop_q;
    pvalid_d = pvalid_q;
    pfail_d = pfail_q;
    rowc_d = rowc_q;
    colc_d = colc_q;
    pbits_d = pbits_q;
    luc_d = luc_q;
    progs_d = progs_q;
    attr_d = attr_q;
    pbytes_d = pbytes_q;
    async_d = async_q;
    strobe_d = strobe_q;
    if (clear_page) begin
      didx_d = 11'h000;
      hits_d = 3'h0;
      stop_d = 1'b0;
      pvalid_d = 1'b0;
      pfail_d = 1'b0;
    end else if (mem_we) begin
      didx_d = didx_q + 11'h001;
      if (sig_hit) begin
        hits_d = hits_q + 3'h1;
      end
      case (off)
        `PP_OFF_PAGE_BYTES, `PP_OFF_PAGE_BYTES + 9'h001,
        `PP_OFF_PAGE_BYTES + 9'h002, `PP_OFF_PAGE_BYTES + 9'h003: begin
          pbytes_d = put_le(pbytes_q, b, off[1:0]);
        end
        `PP_OFF_LU_COUNT: luc_d = b;
        `PP_OFF_ADDR_CYC: begin
          rowc_d = b[3:0];
          colc_d = b[7:4];
        end
        `PP_OFF_PROGS: progs_d = b;
        `PP_OFF_PLANE_BITS: pbits_d = b[3:0];
        `PP_OFF_MP_ATTR: attr_d = b[2:0];
        `PP_OFF_ASYNC_GRADE: async_d = b[5:0];
        `PP_OFF_STROBE_GRADE: strobe_d[7:0] = b;
        `PP_OFF_STROBE_GRADE + 9'h001: strobe_d[8] = b[0];
        `PP_OFF_COPY_LAST: begin
          hits_d = 3'h0;
          if (hits_q >= `PP_SIG_MIN_HITS) begin
            pvalid_d = 1'b1;
            stop_d = 1'b1;
          end else if (didx_q[10:9] == `PP_COPIES - 2'h1) begin
            pfail_d = 1'b1;
            stop_d = 1'b1;
          end
          // Otherwise the next redundant copy overwrites this one
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      didx_q <= 11'h000;
      hits_q <= 3'h0;
      stop_q <= 1'b0;
      pvalid_q <= 1'b0;
      pfail_q <= 1'b0;
      rowc_q <= 4'h0;
      colc_q <= 4'h0;
      pbits_q <= 4'h0;
      luc_q <= `PP_FIELD_RESET;
      progs_q <= `PP_FIELD_RESET;
      attr_q <= 3'h0;
      pbytes_q <= 32'h0000_0000;
      async_q <= 6'h00;
      strobe_q <= 9'h000;
    end else begin
      didx_q <= didx_d;
      hits_q <= hits_d;
      stop_q <= stop_d;
      pvalid_q <= pvalid_d;
      pfail_q <= pfail_d;
      rowc_q <= rowc_d;
      colc_q <= colc_d;
      pbits_q <= pbits_d;
      luc_q <= luc_d;
      progs_q <= progs_d;
      attr_q <= attr_d;
      pbytes_q <= pbytes_d;
      async_q <= async_d;
      strobe_q <= strobe_d;
    end
  end

  // ==========================================
  // Pin sequencer and operation checks
  host_state_t st_q, st_d;
  logic ph_q, ph_d, rdpar_q, rdpar_d, cle_q, cle_d, ale_q, ale_d;
  logic we_n_q, we_n_d, re_n_q, re_n_d, ce_n_q, ce_n_d, oe_q, oe_d;
  logic done_q, done_d, ref_q, ref_d, cache_on_q, cache_on_d;
  logic [7:0] dqo_q, dqo_d, wb_q, wb_d, pcnt_q, pcnt_d;
  logic [63:0] ash_q, ash_d;
  logic [4:0] acnt_q, acnt_d;
  logic [10:0] rcnt_q, rcnt_d;
  logic [23:0] prow_q, prow_d;
  logic [3:0] cplane_q, cplane_d;
  logic refuse, cache_bad;

  assign clear_page = (st_q == ST_IDLE) && page_start;
  assign fill_s.data = dq_q;
  assign fill_s.valid = (st_q == ST_RD) && ph_q && tick && !stop_q;

  always_comb begin
    cache_bad = 1'b0;
    if (op_cache && op_multi_plane) begin
      cache_bad = op_copyback ||
                  (op_kind == OP_PROGRAM && !attr_q[`PP_ATTR_PROG_CACHE]) ||
                  (op_kind == OP_READ && !attr_q[`PP_ATTR_READ_CACHE]);
    end
    refuse = !pvalid_q || cache_bad ||
             (op_logical_unit >= luc_q) ||
             (op_kind == OP_PROGRAM && op_row == prow_q && pcnt_q >= progs_q) ||
             (op_cache && cache_on_q && !attr_q[`PP_ATTR_PLANE_FREE] && op_plane != cplane_q);
  end

  always_comb begin
    st_d = st_q;
    ph_d = ph_q;
    rdpar_d = rdpar_q;
    cle_d = cle_q;
    ale_d = ale_q;
    we_n_d = we_n_q;
    re_n_d = re_n_q;
    ce_n_d = ce_n_q;
    oe_d = oe_q;
    dqo_d = dqo_q;
    wb_d = wb_q;
    ash_d = ash_q;
    acnt_d = acnt_q;
    rcnt_d = rcnt_q;
    pcnt_d = pcnt_q;
    prow_d = prow_q;
    cache_on_d = cache_on_q;
    cplane_d = cplane_q;
    done_d = 1'b0;
    ref_d = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (page_start) begin
          st_d = ST_WR;
          rdpar_d = 1'b1;
          dqo_d = `PP_CMD_READ_PARAM;
          ash_d = {56'h0, `PP_ADDR_PARAM};
          acnt_d = 5'h01;
          ph_d = 1'b0;
        end else if (op_valid && refuse) begin
          ref_d = 1'b1;
        end else if (op_valid) begin
          st_d = ST_WR;
          rdpar_d = 1'b0;
          dqo_d = op_cmd;
          ph_d = 1'b0;
          if (op_kind == OP_ERASE) begin
            ash_d = {40'h0, op_row};
            acnt_d = {1'b0, rowc_q};
            pcnt_d = 8'h00;
          end else begin
            ash_d = pack_addr(op_col, op_row, colc_q);
            acnt_d = 5'({1'b0, colc_q} + {1'b0, rowc_q});
          end
          if (op_kind == OP_PROGRAM) begin
            pcnt_d = (op_row == prow_q) ? pcnt_q + 8'h01 : 8'h01;
            prow_d = op_row;
          end
          cache_on_d = op_cache;
          if (op_cache && !cache_on_q) begin
            cplane_d = op_plane;
          end
        end
      end
      ST_WR: begin
        if (tick) begin
          ce_n_d = 1'b0;
          ph_d = !ph_q;
          we_n_d = 1'b1;
          // Pins move as the strobe falls or while it stays high, never as it rises, so they hold across its rising edge
          if (!ph_q && (cle_q || ale_q) && acnt_q == 5'h00) begin
            oe_d = 1'b0;
            cle_d = 1'b0;
            ale_d = 1'b0;
            if (rdpar_q) begin
              st_d = ST_WAIT_WB;
              wb_d = 8'h00;
            end else begin
              st_d = ST_IDLE;
              done_d = 1'b1;
              ce_n_d = 1'b1;
            end
          end else if (!ph_q) begin
            we_n_d = 1'b0;
            oe_d = 1'b1;
            cle_d = !cle_q && !ale_q;
            ale_d = cle_q || ale_q;
            if (cle_q || ale_q) begin
              dqo_d = ash_q[7:0];
              ash_d = ash_q >> 8;
              acnt_d = acnt_q - 5'h01;
            end
          end
        end
      end
      ST_WAIT_WB: begin
        // Busy is only trusted after the device has had time to drop ready
        wb_d = wb_q + 8'h01;
        if (wb_q >= WB_CYC + 8'h03) begin
          st_d = ST_WAIT_RDY;
        end
      end
      ST_WAIT_RDY: begin
        if (rb_q) begin
          st_d = ST_RD;
          ph_d = 1'b0;
          rcnt_d = 11'h000;
        end
      end
      ST_RD: begin
        if (stop_q || rcnt_q == READ_LIMIT) begin
          st_d = ST_FLUSH;
          re_n_d = 1'b1;
        end else if (tick && (ph_q || fill_s.ready)) begin
          ph_d = !ph_q;
          re_n_d = ph_q;
          if (ph_q) begin
            rcnt_d = rcnt_q + 11'h001;
          end
        end
      end
      ST_FLUSH: begin
        if (!drain_s.valid) begin
          st_d = ST_IDLE;
          ce_n_d = 1'b1;
          rdpar_d = 1'b0;
          done_d = 1'b1;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ST_IDLE;
      ph_q <= 1'b0;
      rdpar_q <= 1'b0;
      cle_q <= 1'b0;
      ale_q <= 1'b0;
      we_n_q <= 1'b1;
      re_n_q <= 1'b1;
      ce_n_q <= 1'b1;
      oe_q <= 1'b0;
      dqo_q <= 8'h00;
      wb_q <= 8'h00;
      ash_q <= 64'h0;
      acnt_q <= 5'h00;
      rcnt_q <= 11'h000;
      pcnt_q <= 8'h00;
      prow_q <= 24'h000000;
      cache_on_q <= 1'b0;
      cplane_q <= 4'h0;
      done_q <= 1'b0;
      ref_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ph_q <= ph_d;
      rdpar_q <= rdpar_d;
      cle_q <= cle_d;
      ale_q <= ale_d;
      we_n_q <= we_n_d;
      re_n_q <= re_n_d;
      ce_n_q <= ce_n_d;
      oe_q <= oe_d;
      dqo_q <= dqo_d;
      wb_q <= wb_d;
      ash_q <= ash_d;
      acnt_q <= acnt_d;
      rcnt_q <= rcnt_d;
      pcnt_q <= pcnt_d;
      prow_q <= prow_d;
      cache_on_q <= cache_on_d;
      cplane_q <= cplane_d;
      done_q <= done_d;
      ref_q <= ref_d;
    end
  end

  // ==========================================
  // Outputs
  assign page_busy = rdpar_q;
  assign page_valid = pvalid_q;
  assign page_fail = pfail_q;
  assign row_cycles = rowc_q;
  assign col_cycles = colc_q;
  assign logical_unit_count = luc_q;
  assign programs_per_page = progs_q;
  assign plane_bits = pbits_q;
  assign mp_attr = attr_q;
  assign page_bytes = pbytes_q;
  assign async_grades = async_q;
  assign strobe_grades = strobe_q;
  assign op_done = done_q;
  assign op_refused = ref_q;
  assign ce_n = ce_n_q;
  assign cle = cle_q;
  assign ale = ale_q;
  assign we_n = we_n_q;
  assign re_n = re_n_q;
  assign dq_out = dqo_q;
  assign dq_oe = oe_q;

endmodule

`default_nettype wire

// ---- param_page_host_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none

module param_page_host_asserts
  import param_page_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // User side
  input wire logic page_start,
  input wire logic page_busy,
  input wire logic [3:0] row_cycles,
  input wire logic [3:0] col_cycles,
  input wire logic op_valid,
  input wire op_kind_t op_kind,
  input wire logic op_done,
  input wire logic op_refused,
  // Flash pins
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic [7:0] dq_out,
  input wire logic dq_oe
);
  // ==========================================
  // Address strobes since the last command strobe
  logic page_q;
  logic erase_q;
  logic [3:0] n_addr_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      page_q <= 1'b0;
      erase_q <= 1'b0;
      n_addr_q <= 4'h0;
    end else begin
      if (page_start) page_q <= 1'b1;
      else if (op_valid) page_q <= 1'b0;
      if (op_valid) erase_q <= (op_kind == OP_ERASE);
      if ($rose(we_n) && cle) n_addr_q <= 4'h0;
      else if ($rose(we_n) && ale) n_addr_q <= n_addr_q + 4'h1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  cmd_byte_a: assert property (page_busy && $fell(we_n) && cle |-> dq_out == 8'hEC && dq_oe && !ale)
    else $error("bad read command");
  addr_byte_a: assert property (page_busy && $fell(we_n) && ale |-> dq_out == 8'h40 && dq_oe && !cle)
    else $error("bad read address");
  strobe_width_a: assert property ($fell(we_n) |-> !we_n [*6] ##1 we_n)
    else $error("bad strobe width");
  bus_hold_a: assert property (!we_n && !$fell(we_n) |-> $stable(dq_out) && $stable(cle) && $stable(ale))
    else $error("bus moved under strobe");
  rise_hold_a: assert property ($rose(we_n) |-> $stable(dq_out) && $stable(cle) && $stable(ale))
    else $error("bus moved at strobe rise");
  read_turn_a: assert property (!re_n |-> !dq_oe && !cle && !ale && !ce_n)
    else $error("read while driving");
  busy_start_a: assert property ($rose(page_busy) |-> $past(page_start))
    else $error("busy without start");
  refuse_prompt_a: assert property ($rose(op_refused) |-> $past(op_valid) || $past(op_valid, 2))
    else $error("late refusal");
  addr_count_a: assert property (op_done && !page_q |=>
    n_addr_q == (erase_q ? row_cycles : row_cycles + col_cycles)) else $error("bad address count");
endmodule

bind param_page_host param_page_host_asserts u_chk (.clk, .rst_b, .page_start, .page_busy, .row_cycles,
  .col_cycles, .op_valid, .op_kind, .op_done, .op_refused, .ce_n, .cle, .ale, .we_n, .re_n, .dq_out, .dq_oe);

`default_nettype wire

// ---- flash_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module flash_model #(
  parameter logic [31:0] SIGS = 32'h0000_0000  // Arbitrary value
) (
  // Flash pins
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic [7:0] dq_out,
  output logic [7:0] dq_in,
  output logic rb_in,
  // Scenario controls and capture
  input wire logic [2:0] bad_copies,
  input wire logic [2:0] bad_bytes,
  input wire logic slow,
  output logic [7:0] last_cmd,
  output logic [3:0] n_addr,
  output logic [63:0] addr_bytes
);
  // ==========================================
  // Page content
  int ptr = 0;
  logic rd_q = 1'b0;
  logic [7:0] last_q = 8'h00;
  function automatic logic [7:0] base(input int o);
    if (o < 4) return SIGS[o*8 +: 8];
    if (o > 32 && o < 64 && o != 44) return 8'h20;
    case (o)
      4: return 8'h02;
      32: return 8'h41;
      44: return 8'h4D;
      81: return 8'h40;
      87, 100, 103: return 8'h02;
      101: return 8'h13;
      104: return 8'h01;
      105: return 8'h03;
      144, 150: return 8'h3F;
      146: return 8'hF0;
      147: return 8'h01;
      510: return 8'h9E;
      511: return 8'h4D;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] byte_at(input int p);
    logic [7:0] v;
    v = base(p % 512);
    if (p < 1536 && bad_copies[p / 512] && p % 512 < int'(bad_bytes)) v = ~v;
    return v;
  endfunction

  // ==========================================
  // Bus behaviour
  initial begin
    rb_in = 1'b1;
    dq_in = 8'hFF;
    last_cmd = 8'h00;
    n_addr = 4'h0;
    addr_bytes = 64'h0;
  end
  always @(posedge we_n) begin
    if (!ce_n && cle) begin
      last_cmd = dq_out;
      n_addr = 4'h0;
      addr_bytes = 64'h0;
      rd_q = 1'b0;
    end else if (!ce_n && ale) begin
      addr_bytes[n_addr*8 +: 8] = dq_out;
      n_addr = n_addr + 4'h1;
      if (last_cmd == 8'hEC && dq_out == 8'h40) begin
        rb_in = 1'b0;
        ptr = 0;
        rd_q = 1'b1;
        // Two busy lengths so quick and slow answers are both seen
        #(slow ? 4000 : 400) rb_in = 1'b1;
      end
    end
  end
  always @(negedge re_n) begin
    if (rd_q && !ce_n && rb_in) begin
      last_q = byte_at(ptr);
      dq_in = last_q;
      ptr = ptr + 1;
    end
  end
  // Released bus must not look like the last byte
  always @(posedge ce_n) dq_in = ~last_q;
endmodule

`default_nettype wire

// ---- param_page_host_tb.sv ----
`timescale 1ns/10ps
`default_nettype none

module param_page_host_tb
  import param_page_pkg::*;
;
  `define CHK(a, e, m) \
    begin n_compared++; if ((a) !== (e)) begin num_errors++; $display("mismatch at %0t: %s", $time, m); end end
  localparam logic [31:0] SIGS = 32'h3CC3_5AA5;  // Arbitrary value
  logic clk = 1'b0;
  logic rst_b, page_start, rd_en, op_valid, op_cache, op_multi_plane, op_copyback, slow;
  logic page_busy, page_valid, page_fail, op_done, op_refused, ce_n, cle, ale, we_n, re_n, dq_oe, rb_in;
  logic [7:0] rd_data, dq_out, dq_in, op_cmd, op_logical_unit, logical_unit_count, programs_per_page, last_cmd;
  logic [8:0] rd_addr, strobe_grades;
  logic [3:0] row_cycles, col_cycles, plane_bits, op_plane, n_addr;
  logic [2:0] mp_attr, bad_copies, bad_bytes;
  logic [31:0] page_bytes, rng;
  logic [5:0] async_grades;
  logic [15:0] op_col;
  logic [23:0] op_row;
  logic [63:0] addr_bytes;
  op_kind_t op_kind;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;

  param_page_host #(.SIG0(SIGS[7:0]), .SIG1(SIGS[15:8]), .SIG2(SIGS[23:16]), .SIG3(SIGS[31:24])) u_dut (
    .clk, .rst_b, .page_start, .page_busy, .page_valid, .page_fail, .rd_en, .rd_addr, .rd_data, .row_cycles,
    .col_cycles, .logical_unit_count, .programs_per_page, .plane_bits, .mp_attr, .page_bytes, .async_grades,
    .strobe_grades, .op_valid, .op_kind, .op_cmd, .op_col, .op_row, .op_logical_unit, .op_plane, .op_cache,
    .op_multi_plane, .op_copyback, .op_done, .op_refused, .ce_n, .cle, .ale, .we_n, .re_n, .dq_out, .dq_oe,
    .dq_in, .rb_in);
  flash_model #(.SIGS(SIGS)) u_flash (.ce_n, .cle, .ale, .we_n, .re_n, .dq_out, .dq_in, .rb_in, .bad_copies,
    .bad_bytes, .slow, .last_cmd, .n_addr, .addr_bytes);

  // ==========================================
  // Clock, timeout and helpers
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      num_errors++;
      conclude();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check_byte(input logic [8:0] a, input int keep);
    @(negedge clk);
    rd_en = 1'b1;
    rd_addr = a;
    @(negedge clk);
    rd_en = 1'b0;
    `CHK(rd_data, u_flash.byte_at(keep * 512 + int'(a)), "stored byte")
  endtask
  task automatic read_page(input logic [2:0] bc, input logic [2:0] bb, input logic ok, input int keep);
    logic [8:0] pick [4] = '{9'h000, 9'h004, 9'h065, 9'h1FF};
    @(negedge clk);
    bad_copies = bc;
    bad_bytes = bb;
    slow = bc[0];
    page_start = 1'b1;
    @(negedge clk);
    page_start = 1'b0;
    `CHK(page_busy, 1'b1, "busy")
    // Holding the store port stalls the drain, so the buffer fills
    for (int n = 0; n < 25000 && op_done !== 1'b1; n++) begin
      rd_en = (n > 900 && n < 1200);
      @(negedge clk);
    end
    rd_en = 1'b0;
    `CHK({page_valid, page_fail}, {ok, !ok}, "verdict")
    for (int n = 0; n < 10 && ok; n++) begin
      rng = xs(rng);
      check_byte(n < 4 ? pick[n] : rng[8:0], keep);
    end
  endtask
  task automatic op(input op_kind_t k, input logic [23:0] r, input logic [7:0] lu, input logic [3:0] pl,
                    input logic [2:0] ccm, input logic refuse);
    rng = xs(rng);
    @(negedge clk);
    op_kind = k;
    op_row = r;
    {op_cmd, op_col} = rng[23:0];
    op_logical_unit = lu;
    op_plane = pl;
    {op_cache, op_multi_plane, op_copyback} = ccm;
    op_valid = 1'b1;
    @(negedge clk);
    op_valid = 1'b0;
    for (int n = 0; n < 500 && op_done !== 1'b1 && op_refused !== 1'b1; n++) @(negedge clk);
    `CHK(op_refused, refuse, "refusal")
    if (!refuse) begin
      `CHK({last_cmd, n_addr}, {op_cmd, k == OP_ERASE ? 4'h3 : 4'h4}, "address cycles")
      `CHK(addr_bytes, k == OP_ERASE ? {40'h0, r} : {32'h0, r, op_col[7:0]}, "address bytes")
    end
  endtask

  // ==========================================
  // Scenarios
  initial begin
    rng = 32'h0000_0018;
    rst_b = 1'b0;
    op_kind = OP_OTHER;
    {page_start, rd_en, rd_addr, op_valid, op_cmd, op_col, op_row, op_logical_unit, op_plane} = '0;
    {op_cache, op_multi_plane, op_copyback, bad_copies, bad_bytes, slow} = '0;
    repeat (12) @(negedge clk);
    `CHK({ce_n, we_n, re_n, dq_oe, page_valid}, 5'b11100, "reset levels")
    rst_b = 1'b1;
    op(OP_READ, 24'h0, 8'h00, 4'h0, 3'b000, 1'b1);
    read_page(3'b000, 3'h0, 1'b1, 0);
    `CHK({row_cycles, col_cycles, logical_unit_count, programs_per_page}, 24'h3102_02, "counts")
    `CHK({plane_bits, mp_attr, page_bytes}, {4'h1, 3'h3, 32'h0000_4000}, "geometry")
    `CHK({async_grades, strobe_grades}, {6'h3F, 9'h1F0}, "grades")
    for (int i = 0; i < 8; i++) begin
      rng = xs(rng);
      op(op_kind_t'(i % 4), rng[31:8], {7'h0, rng[0]}, 4'h0, 3'b000, 1'b0);
    end
    for (int i = 0; i < 5; i++) op(i == 3 ? OP_ERASE : OP_PROGRAM, 24'h000123, 8'h01, 4'h0, 3'b000, i == 2);
    op(OP_READ, 24'h0, 8'h02, 4'h0, 3'b000, 1'b1);
    op(OP_READ, 24'h0, 8'h00, 4'h1, 3'b110, 1'b0);
    op(OP_READ, 24'h0, 8'h00, 4'h2, 3'b110, 1'b1);
    op(OP_READ, 24'h0, 8'h00, 4'h1, 3'b111, 1'b1);
    op(OP_PROGRAM, 24'h5, 8'h00, 4'h1, 3'b111, 1'b1);
    read_page(3'b001, 3'h2, 1'b1, 0);
    read_page(3'b011, 3'h3, 1'b1, 2);
    read_page(3'b111, 3'h3, 1'b0, 0);
    op(OP_READ, 24'h0, 8'h00, 4'h0, 3'b000, 1'b1);
    conclude();
  end
endmodule

`default_nettype wire
